// >>> rtl/program_data_address_map.sv
`timescale 1ns/1ns
// Contract
// - A program location is a 24-bit word made of a lower 16-bit word and an upper word whose top byte reads zero.
// - The lower word of a location sits at the even address and the upper word at the next odd address.
// - Program addresses align on the lower word and the program counter moves by two per location.
// - Program addresses below 0x000200 hold only the fixed vectors, never general code.
// - After reset the program counter is 0x000000, where firmware keeps a jump whose target sits at 0x000002.
// - Two vector tables exist, the primary from 0x000004 to 0x0000FF and the alternate from 0x000100 to 0x0001FF.
// - Every interrupt source has its own vector entry and thus its own service routine; the primary table refuses indices 126 and 127.
// - Data space is sixteen bits wide and separate from program memory.
// - Data reads and writes take their addresses from separate read and write address units.
// - A data effective address is 16 bits and selects a byte, covering 64 Kbytes or 32K words.
// - Addresses with bit 15 clear reach data memory, with bit 15 set the program space window.
// - At most 16 Kbytes of data memory exist and reads outside it return zero.
// - The low byte of a data word is at the even byte address, the high byte at the odd one.
// - A word access at an odd data address traps; the write is dropped, the read completes.
module program_data_address_map
  import pdm_pkg::*;
#(
  parameter int DATA_BYTES = DATA_IMPL_BYTES,
  parameter int PROG_WORDS = PROG_IMPL_WORDS
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic clkEn,
  input wire logic pcAdvance,
  input wire logic pcBackward,
  input wire logic pcLoad,
  input wire logic [PC_BITS-1:0] pcLoadAddr,
  input wire logic vecReq,
  input wire logic vecAlt,
  input wire logic [VEC_IDX_BITS-1:0] vecIndex,
  output logic [PC_BITS-1:0] programCounter,
  output logic [INSN_BITS-1:0] fetchWord,
  output logic vecTaken,
  output logic jumpRefused,
  input wire logic progWrEn,
  input wire logic [PC_BITS-1:0] progWrAddr,
  input wire logic [INSN_BITS-1:0] progWrData,
  input wire logic [WINDOW_PAGE_BITS-1:0] windowPage,
  input wire logic windowUpper,
  input wire logic rdReq,
  input wire logic rdByte,
  input wire logic [EA_BITS-1:0] rdEa,
  output logic [DATA_BITS-1:0] rdData,
  output logic rdValid,
  input wire logic wrReq,
  input wire logic wrByte,
  input wire logic [EA_BITS-1:0] wrEa,
  input wire logic [DATA_BITS-1:0] wrData,
  output logic wrDone,
  output logic wrIgnored,
  output logic addrErrTrap
);

  // ----------------------------------------------------------------
  // Derived sizes
  // ----------------------------------------------------------------
  localparam int DATA_WORDS = DATA_BYTES / 2;
  localparam int DIDX_BITS = $clog2(DATA_WORDS);
  localparam int PIDX_BITS = $clog2(PROG_WORDS);
  localparam logic [EA_BITS-1:0] DATA_LIMIT = EA_BITS'(DATA_BYTES);
  localparam logic [PC_BITS-2:0] PROG_LIMIT = (PC_BITS-1)'(PROG_WORDS);

  // ----------------------------------------------------------------
  // Program memory
  // ----------------------------------------------------------------
  // Only 24 bits are stored per location; the top byte of the upper word has no cells
  logic [INSN_BITS-1:0] progMem [PROG_WORDS];
  logic progWrOk;

  // Whole location at the even address of a lower word
  function automatic logic [INSN_BITS-1:0] progWordAt(input logic [PC_BITS-1:0] addr);
    logic [PC_BITS-2:0] idx;
    idx = addr[PC_BITS-1:1];
    if (idx < PROG_LIMIT) begin
      progWordAt = progMem[idx[PIDX_BITS-1:0]];
    end else begin
      progWordAt = INSN_ZERO;
    end
  endfunction

  // One 16-bit half: even address is the lower word, odd the upper
  function automatic logic [DATA_BITS-1:0] progHalfAt(input logic [PC_BITS-1:0] addr);
    logic [INSN_BITS-1:0] word;
    word = progWordAt({addr[PC_BITS-1:1], 1'b0});
    if (addr[0]) begin
      progHalfAt = {UPPER_PAD, word[INSN_BITS-1:DATA_BITS]};
    end else begin
      progHalfAt = word[DATA_BITS-1:0];
    end
  endfunction

  // Loads land on whole locations only, so an odd address is dropped
  assign progWrOk = progWrEn && !progWrAddr[0]
                    && (progWrAddr[PC_BITS-1:1] < PROG_LIMIT);

  always_ff @(posedge mclk) begin
    if (clkEn && progWrOk) begin
      progMem[progWrAddr[PIDX_BITS:1]] <= progWrData;
    end
  end

  // ----------------------------------------------------------------
  // Program counter and vector sequencer
  // ----------------------------------------------------------------
  seq_state_t stateReg;
  seq_state_t stateNext;
  logic [PC_BITS-1:0] pc_reg;
  logic [PC_BITS-1:0] pc_next;
  logic [INSN_BITS-1:0] fetch_reg;
  logic [INSN_BITS-1:0] fetch_next;
  logic vecTaken_reg;
  logic vecTaken_next;
  logic jumpRefused_reg;
  logic jumpRefused_next;
  logic [PC_BITS-1:0] vecAddr;
  logic vecOk;
  logic [INSN_BITS-1:0] vecEntry;

  // Each source index picks its own two-address slot in the chosen table, except indices 126 and 127 in the primary table, which are refused
  always_comb begin
    if (vecAlt) begin
      vecAddr = ALT_TABLE_FIRST + {{(PC_BITS-VEC_IDX_BITS-1){1'b0}}, vecIndex, 1'b0};
      vecOk = (vecAddr <= ALT_TABLE_LAST);
    end else begin
      vecAddr = PRI_TABLE_FIRST + {{(PC_BITS-VEC_IDX_BITS-1){1'b0}}, vecIndex, 1'b0};
      vecOk = (vecAddr <= PRI_TABLE_LAST);
    end
  end

  assign vecEntry = progWordAt(pc_reg);

  always_comb begin
    stateNext = stateReg;
    pc_next = pc_reg;
    vecTaken_next = 1'b0;
    jumpRefused_next = 1'b0;
    case (stateReg)
      ST_RESET: begin
        pc_next = PC_RESET_VALUE;
        stateNext = ST_RUN;
      end
      ST_RUN: begin
        if (vecReq) begin
          if (vecOk) begin
            pc_next = vecAddr;
            stateNext = ST_VECTOR;
          end else begin
            jumpRefused_next = 1'b1;
          end
        end else if (pcLoad) begin
          // The vector area is not a place to run general code
          if (pcLoadAddr < VECTOR_REGION_END) begin
            jumpRefused_next = 1'b1;
          end else begin
            pc_next = {pcLoadAddr[PC_BITS-1:1], 1'b0};
          end
        end else if (pcAdvance) begin
          if (pcBackward) begin
            pc_next = pc_reg - PC_STEP;
          end else begin
            pc_next = pc_reg + PC_STEP;
          end
        end
      end
      ST_VECTOR: begin
        // The slot holds the service routine address, forced onto a lower word
        pc_next = {vecEntry[PC_BITS-1:1], 1'b0};
        vecTaken_next = 1'b1;
        stateNext = ST_RUN;
      end
      default: begin
        pc_next = PC_RESET_VALUE;
        stateNext = ST_RESET;
      end
    endcase
    // Fetch follows the new counter so the word lines up with it
    fetch_next = progWordAt(pc_next);
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      stateReg <= ST_RESET;
      pc_reg <= PC_RESET_VALUE;
      fetch_reg <= INSN_ZERO;
      vecTaken_reg <= 1'b0;
      jumpRefused_reg <= 1'b0;
    end else if (clkEn) begin
      stateReg <= stateNext;
      pc_reg <= pc_next;
      fetch_reg <= fetch_next;
      vecTaken_reg <= vecTaken_next;
      jumpRefused_reg <= jumpRefused_next;
    end
  end

  assign programCounter = pc_reg;
  assign fetchWord = fetch_reg;
  assign vecTaken = vecTaken_reg;
  assign jumpRefused = jumpRefused_reg;

  // ----------------------------------------------------------------
  // Data memory, kept apart from program memory
  // ----------------------------------------------------------------
  data_ram_if #(.IDX_BITS(DIDX_BITS)) ramBus ();

  data_ram #(
    .WORDS(DATA_WORDS)
  ) u_data_ram (
    .mclk(mclk),
    .clkEn(clkEn),
    .bus(ramBus.ram)
  );

  // ----------------------------------------------------------------
  // Read address unit
  // ----------------------------------------------------------------
  logic rdWindow;
  logic rdImpl;
  logic rdMis;
  logic [PC_BITS-1:0] rdProgAddr;
  logic [DATA_BITS-1:0] rdWord;
  logic [DATA_BITS-1:0] rdData_reg;
  logic [DATA_BITS-1:0] rdData_next;
  logic rdValid_reg;
  logic rdValid_next;

  // Low byte lane at the even address, high lane at the odd one
  function automatic logic [DATA_BITS-1:0] byteLane(input logic [DATA_BITS-1:0] word, input logic odd);
    if (odd) begin
      byteLane = {BYTE_ZERO, word[DATA_BITS-1:BYTE_BITS]};
    end else begin
      byteLane = {BYTE_ZERO, word[BYTE_BITS-1:0]};
    end
  endfunction

  assign rdWindow = rdEa[EA_WINDOW_BIT];
  assign rdImpl = !rdWindow && (rdEa < DATA_LIMIT);
  assign rdMis = !rdByte && rdEa[0];
  assign rdProgAddr = {1'b0, windowPage, rdEa[EA_WINDOW_BIT-1:1], windowUpper};
  assign ramBus.rdIdx = rdEa[DIDX_BITS:1];

  always_comb begin
    if (rdWindow) begin
      rdWord = progHalfAt(rdProgAddr);
    end else if (rdImpl) begin
      rdWord = ramBus.rdData;
    end else begin
      rdWord = DATA_ZERO;
    end
    // A misaligned word read still completes, with the containing word
    if (rdByte) begin
      rdData_next = byteLane(rdWord, rdEa[0]);
    end else begin
      rdData_next = rdWord;
    end
    rdValid_next = rdReq;
    if (!rdReq) begin
      rdData_next = rdData_reg;
    end
  end

  // ----------------------------------------------------------------
  // Write address unit
  // ----------------------------------------------------------------
  logic wrWindow;
  logic wrImpl;
  logic wrMis;
  logic wrGo;
  logic wrDone_reg;
  logic wrDone_next;
  logic wrIgnored_reg;
  logic wrIgnored_next;
  logic trap_reg;
  logic trap_next;

  assign wrWindow = wrEa[EA_WINDOW_BIT];
  assign wrImpl = !wrWindow && (wrEa < DATA_LIMIT);
  assign wrMis = !wrByte && wrEa[0];
  // The window is read-only; a misaligned word write never reaches the array
  assign wrGo = wrReq && wrImpl && !wrMis;

  assign ramBus.wrEn = wrGo;
  assign ramBus.wrIdx = wrEa[DIDX_BITS:1];
  assign ramBus.wrData = wrByte ? {wrData[BYTE_BITS-1:0], wrData[BYTE_BITS-1:0]} : wrData;
  assign ramBus.wrByteEn = !wrByte ? LANE_BOTH : (wrEa[0] ? LANE_ODD : LANE_EVEN);

  always_comb begin
    wrDone_next = wrReq;
    wrIgnored_next = wrReq && !wrGo;
    trap_next = (rdReq && rdMis) || (wrReq && wrMis);
  end

  // ----------------------------------------------------------------
  // Data side registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rdData_reg <= DATA_ZERO;
      rdValid_reg <= 1'b0;
      wrDone_reg <= 1'b0;
      wrIgnored_reg <= 1'b0;
      trap_reg <= 1'b0;
    end else if (clkEn) begin
      rdData_reg <= rdData_next;
      rdValid_reg <= rdValid_next;
      wrDone_reg <= wrDone_next;
      wrIgnored_reg <= wrIgnored_next;
      trap_reg <= trap_next;
    end
  end

  assign rdData = rdData_reg;
  assign rdValid = rdValid_reg;
  assign wrDone = wrDone_reg;
  assign wrIgnored = wrIgnored_reg;
  assign addrErrTrap = trap_reg;

endmodule

// >>> rtl/pdm_pkg.sv
package pdm_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int INSN_BITS = 24;
  localparam int PC_BITS = 24;
  localparam int DATA_BITS = 16;
  localparam int EA_BITS = 16;
  localparam int BYTE_BITS = 8;
  localparam int EA_WINDOW_BIT = 15;
  localparam int WINDOW_PAGE_BITS = 8;
  localparam int VEC_IDX_BITS = 7;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int DATA_IMPL_BYTES = 16384;
  localparam int PROG_IMPL_WORDS = 4096;

  // ----------------------------------------------------------------
  // Program space map
  // ----------------------------------------------------------------
  localparam logic [23:0] PC_RESET_VALUE = 24'h00_0000;
  localparam logic [23:0] JUMP_TARGET_ADDR = 24'h00_0002;
  localparam logic [23:0] VECTOR_REGION_END = 24'h00_0200;
  localparam logic [23:0] PRI_TABLE_FIRST = 24'h00_0004;
  localparam logic [23:0] PRI_TABLE_LAST = 24'h00_00FF;
  localparam logic [23:0] ALT_TABLE_FIRST = 24'h00_0100;
  localparam logic [23:0] ALT_TABLE_LAST = 24'h00_01FF;
  localparam logic [23:0] PC_STEP = 24'h00_0002;

  // ----------------------------------------------------------------
  // Fill values and lane enables
  // ----------------------------------------------------------------
  localparam logic [7:0] UPPER_PAD = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [15:0] DATA_ZERO = 16'h0000;
  localparam logic [23:0] INSN_ZERO = 24'h00_0000;
  localparam logic [1:0] LANE_EVEN = 2'h1;
  localparam logic [1:0] LANE_ODD = 2'h2;
  localparam logic [1:0] LANE_BOTH = 2'h3;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_RUN = 2'b01,
    ST_VECTOR = 2'b11
  } seq_state_t;

endpackage

// >>> rtl/data_ram_if.sv
`timescale 1ns/1ns
interface data_ram_if #(
  parameter int IDX_BITS = 13
);
  logic [IDX_BITS-1:0] rdIdx;
  logic [15:0] rdData;
  logic [IDX_BITS-1:0] wrIdx;
  logic [15:0] wrData;
  logic [1:0] wrByteEn;
  logic wrEn;

  modport ctrl (
    output rdIdx,
    output wrIdx,
    output wrData,
    output wrByteEn,
    output wrEn,
    input rdData
  );

  modport ram (
    input rdIdx,
    input wrIdx,
    input wrData,
    input wrByteEn,
    input wrEn,
    output rdData
  );
endinterface

// >>> rtl/data_ram.sv
`timescale 1ns/1ns
module data_ram
  import pdm_pkg::*;
#(
  parameter int WORDS = 8192
) (
  input wire logic mclk,
  input wire logic clkEn,
  data_ram_if.ram bus
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // No reset on the array: contents are data, not control state
  logic [DATA_BITS-1:0] mem [WORDS];

  assign bus.rdData = mem[bus.rdIdx];

  // Two byte-wide halves share the word decode, separate write lines
  always_ff @(posedge mclk) begin
    if (clkEn && bus.wrEn) begin
      if (bus.wrByteEn[0]) begin
        mem[bus.wrIdx][BYTE_BITS-1:0] <= bus.wrData[BYTE_BITS-1:0];
      end
      if (bus.wrByteEn[1]) begin
        mem[bus.wrIdx][DATA_BITS-1:BYTE_BITS] <= bus.wrData[DATA_BITS-1:BYTE_BITS];
      end
    end
  end

endmodule

// >>> verif/program_data_address_map_monitor.sv
`timescale 1ns/1ns
module program_data_address_map_monitor
  import pdm_pkg::*;
#(
  parameter int DATA_BYTES = DATA_IMPL_BYTES
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic clkEn,
  input wire logic pcAdvance,
  input wire logic pcBackward,
  input wire logic pcLoad,
  input wire logic [PC_BITS-1:0] pcLoadAddr,
  input wire logic vecReq,
  input wire logic [PC_BITS-1:0] programCounter,
  input wire logic jumpRefused,
  input wire logic rdReq,
  input wire logic rdByte,
  input wire logic [EA_BITS-1:0] rdEa,
  input wire logic [DATA_BITS-1:0] rdData,
  input wire logic rdValid,
  input wire logic wrReq,
  input wire logic wrByte,
  input wire logic [EA_BITS-1:0] wrEa,
  input wire logic wrDone,
  input wire logic wrIgnored,
  input wire logic addrErrTrap
);
  // ----
  // Request filter
  // ----
  // The sequencer drops requests right after reset and after a vector, so those cycles prove nothing
  logic runOk;
  logic vecLast;
  logic pcReady;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      runOk <= 1'b0;
      vecLast <= 1'b0;
    end else if (clkEn) begin
      runOk <= 1'b1;
      vecLast <= vecReq;
    end
  end
  assign pcReady = clkEn && runOk && !vecLast;
  default clocking dc @(posedge mclk);
  endclocking
  default disable iff (!rst_b);
  // ----
  // Checks
  // ----
  property p_reset_pc;
    $rose(rst_b) |-> programCounter == PC_RESET_VALUE;
  endproperty
  a_reset_pc: assert property (p_reset_pc) else $error("pc not at reset value");
  property p_pc_step;
    pcReady && pcAdvance && !pcLoad && !vecReq |=>
      programCounter == $past(programCounter) + ($past(pcBackward) ? 24'hFF_FFFE : PC_STEP);
  endproperty
  a_pc_step: assert property (p_pc_step) else $error("pc step wrong");
  property p_load_refused;
    pcReady && pcLoad && !vecReq && pcLoadAddr < VECTOR_REGION_END |=> jumpRefused && $stable(programCounter);
  endproperty
  a_load_refused: assert property (p_load_refused) else $error("jump into vector area taken");
  property p_rd_valid;
    clkEn && rdReq |=> rdValid;
  endproperty
  a_rd_valid: assert property (p_rd_valid) else $error("read answer missing");
  property p_rd_quiet;
    clkEn && !rdReq |=> !rdValid;
  endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("read answer without request");
  property p_wr_done;
    clkEn && wrReq |=> wrDone;
  endproperty
  a_wr_done: assert property (p_wr_done) else $error("write answer missing");
  property p_trap;
    clkEn && ((rdReq && !rdByte && rdEa[0]) || (wrReq && !wrByte && wrEa[0])) |=> addrErrTrap;
  endproperty
  a_trap: assert property (p_trap) else $error("odd word access without trap");
  property p_rd_beyond;
    clkEn && rdReq && !rdEa[EA_WINDOW_BIT] && rdEa >= DATA_BYTES |=> rdData == DATA_ZERO;
  endproperty
  a_rd_beyond: assert property (p_rd_beyond) else $error("read beyond ram not zero");
  property p_wr_ign;
    clkEn && wrReq && (wrEa[EA_WINDOW_BIT] || wrEa >= DATA_BYTES) |=> wrIgnored;
  endproperty
  a_wr_ign: assert property (p_wr_ign) else $error("write outside ram not refused");
endmodule

bind program_data_address_map program_data_address_map_monitor #(.DATA_BYTES(DATA_BYTES)) mon_inst (
  .mclk(mclk), .rst_b(rst_b), .clkEn(clkEn), .pcAdvance(pcAdvance), .pcBackward(pcBackward),
  .pcLoad(pcLoad), .pcLoadAddr(pcLoadAddr), .vecReq(vecReq), .programCounter(programCounter),
  .jumpRefused(jumpRefused), .rdReq(rdReq), .rdByte(rdByte), .rdEa(rdEa), .rdData(rdData),
  .rdValid(rdValid), .wrReq(wrReq), .wrByte(wrByte), .wrEa(wrEa), .wrDone(wrDone),
  .wrIgnored(wrIgnored), .addrErrTrap(addrErrTrap)
);

// >>> verif/core_model.sv
`timescale 1ns/1ns
module core_model (
  input wire logic mclk,
  output logic rdReq,
  output logic rdByte,
  output logic [15:0] rdEa,
  output logic wrReq,
  output logic wrByte,
  output logic [15:0] wrEa,
  output logic [15:0] wrData
);
  initial begin
    {rdReq, rdByte, wrReq, wrByte} = 4'h0;
    {rdEa, wrEa, wrData} = 48'h0000_0000_0000;
  end
  // ----
  // Data access
  // ----
  // Read and write addresses come from separate units, 16-bit byte addresses
  // Released lines show inverted values so stale data cannot pass for an answer
  task automatic acc(input logic w, b, input logic [15:0] a, d);
    @(posedge mclk) #1;
    if (w) begin
      wrReq = 1'b1;
      wrByte = b;
      wrEa = a;
      wrData = d;
    end else begin
      rdReq = 1'b1;
      rdByte = b;
      rdEa = a;
    end
    @(posedge mclk) #1;
    {rdReq, wrReq} = 2'h0;
    {rdByte, wrByte, rdEa, wrEa, wrData} = ~{rdByte, wrByte, rdEa, wrEa, wrData};
  endtask
endmodule

// >>> verif/program_data_address_map_tb_top.sv
`timescale 1ns/1ns
module program_data_address_map_tb_top
  import pdm_pkg::*;
;
  logic mclk, rst_b, clkEn, pcAdvance, pcBackward, pcLoad, vecReq, vecAlt, progWrEn, windowUpper;
  logic rdReq, rdByte, wrReq, wrByte, rdValid, wrDone, wrIgnored, addrErrTrap, vecTaken, jumpRefused;
  logic [23:0] pcLoadAddr, progWrAddr, progWrData, programCounter, fetchWord;
  logic [15:0] rdEa, wrEa, wrData, rdData;
  logic [6:0] vecIndex;
  logic [7:0] windowPage;
  int error_cnt = 0;
  int checked = 0;
  typedef struct {logic w, b, u, trap, ign; logic [15:0] ea, dat, exp;} row_t;
  // Fields: write, byte, upper half, trap, ignored, address, write data, read data
  row_t rows [15] = '{
    '{1, 0, 0, 0, 0, 16'h0010, 16'hA5C3, 0}, '{0, 0, 0, 0, 0, 16'h0010, 0, 16'hA5C3},
    '{0, 1, 0, 0, 0, 16'h0010, 0, 16'h00C3}, '{0, 1, 0, 0, 0, 16'h0011, 0, 16'h00A5},
    '{1, 1, 0, 0, 0, 16'h0011, 16'hFF7E, 0}, '{0, 0, 0, 0, 0, 16'h0010, 0, 16'h7EC3},
    '{1, 0, 0, 0, 0, 16'h00FE, 16'h1234, 0}, '{1, 0, 0, 1, 1, 16'h00FF, 16'hFFFF, 0},
    '{0, 0, 0, 1, 0, 16'h00FF, 0, 16'h1234}, '{1, 0, 0, 0, 1, 16'h0100, 16'h5555, 0},
    '{0, 0, 0, 0, 0, 16'h0100, 0, 16'h0000}, '{1, 0, 0, 0, 1, 16'h8010, 16'h5555, 0},
    '{0, 0, 0, 0, 0, 16'h8010, 0, 16'hBCDE}, '{0, 0, 1, 0, 0, 16'h8010, 0, 16'h009A},
    '{0, 0, 0, 0, 0, 16'hFFFE, 0, 16'h0000}};

  program_data_address_map #(.DATA_BYTES(256), .PROG_WORDS(512)) program_data_address_map_inst (
    .mclk(mclk), .rst_b(rst_b), .clkEn(clkEn), .pcAdvance(pcAdvance), .pcBackward(pcBackward),
    .pcLoad(pcLoad), .pcLoadAddr(pcLoadAddr), .vecReq(vecReq), .vecAlt(vecAlt), .vecIndex(vecIndex),
    .programCounter(programCounter), .fetchWord(fetchWord), .vecTaken(vecTaken), .jumpRefused(jumpRefused),
    .progWrEn(progWrEn), .progWrAddr(progWrAddr), .progWrData(progWrData), .windowPage(windowPage),
    .windowUpper(windowUpper), .rdReq(rdReq), .rdByte(rdByte), .rdEa(rdEa), .rdData(rdData),
    .rdValid(rdValid), .wrReq(wrReq), .wrByte(wrByte), .wrEa(wrEa), .wrData(wrData), .wrDone(wrDone),
    .wrIgnored(wrIgnored), .addrErrTrap(addrErrTrap));
  core_model core_model_inst (.mclk(mclk), .rdReq(rdReq), .rdByte(rdByte), .rdEa(rdEa), .wrReq(wrReq),
    .wrByte(wrByte), .wrEa(wrEa), .wrData(wrData));

  // ----
  // Helpers
  // ----
  task automatic chk(input string nm, input logic [23:0] e, s);
    checked++;
    if (s !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, s);
      error_cnt++;
    end
  endtask
  task automatic complete_run;
    $display("checked %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic pw(input logic [23:0] a, d);
    @(posedge mclk) #1;
    {progWrAddr, progWrData, progWrEn} = {a, d, 1'b1};
    @(posedge mclk) #1 progWrEn = 0;
  endtask
  task automatic pc(input logic adv, back, ld, input logic [23:0] a);
    @(posedge mclk) #1;
    {pcAdvance, pcBackward, pcLoad, pcLoadAddr} = {adv, back, ld, a};
    @(posedge mclk) #1;
    {pcAdvance, pcLoad} = 2'h0;
  endtask
  task automatic vec(input logic alt, input logic [6:0] idx, input logic [23:0] slot, target);
    @(posedge mclk) #1;
    {vecReq, vecAlt, vecIndex} = {1'b1, alt, idx};
    @(posedge mclk) #1 vecReq = 0;
    chk("slot", slot, programCounter);
    @(posedge mclk) #1;
    chk("isr", target, programCounter);
    chk("vecTaken", 1, vecTaken);
  endtask

  // ----
  // Stimulus
  // ----
  initial begin
    mclk = 0;
    forever #4 mclk = ~mclk;
  end
  initial begin
    #20000;
    error_cnt++;
    complete_run();
  end
  initial begin
    {rst_b, clkEn, pcAdvance, pcBackward, pcLoad, vecReq, vecAlt, progWrEn, windowUpper} = 9'h080;
    {pcLoadAddr, progWrAddr, progWrData, vecIndex, windowPage} = 87'h0;
    repeat (8) @(posedge mclk);
    #1 rst_b = 1;
    pw(24'h00_0000, 24'h04_0200);
    pw(24'h00_0002, 24'h00_0200);
    pw(24'h00_000A, 24'h00_0301);
    pw(24'h00_0100, 24'h00_0220);
    pw(24'h00_0010, 24'h9A_BCDE);
    pw(24'h00_0200, 24'h12_3456);
    pw(24'h00_0202, 24'h65_4321);
    // Second reset in mid-run: program memory keeps its contents
    @(posedge mclk) #1 rst_b = 0;
    @(posedge mclk) #1 rst_b = 1;
    @(posedge mclk) #1;
    chk("pc", 24'h00_0000, programCounter);
    chk("fetch", 24'h04_0200, fetchWord);
    foreach (rows[i]) begin
      windowUpper = rows[i].u;
      core_model_inst.acc(rows[i].w, rows[i].b, rows[i].ea, rows[i].dat);
      chk("trap", rows[i].trap, addrErrTrap);
      if (rows[i].w) begin
        chk("wrIgnored", rows[i].ign, wrIgnored);
        chk("wrDone", 1, wrDone);
      end else begin
        chk("rdData", rows[i].exp, rdData);
        chk("rdValid", 1, rdValid);
      end
    end
    // Page bits must reach the window address: page 1 lies beyond the loaded program
    windowPage = 8'h01;
    core_model_inst.acc(0, 0, 16'h8010, 16'h0000);
    chk("rdData", 16'h0000, rdData);
    windowPage = 8'h00;
    pc(0, 0, 1, 24'h00_0100);
    chk("refused", 1, jumpRefused);
    chk("pc", 24'h00_0000, programCounter);
    pc(0, 0, 1, 24'h00_0201);
    chk("pc", 24'h00_0200, programCounter);
    chk("fetch", 24'h12_3456, fetchWord);
    pc(1, 0, 0, 0);
    chk("fetch", 24'h65_4321, fetchWord);
    pc(1, 1, 0, 0);
    chk("pc", 24'h00_0200, programCounter);
    clkEn = 0;
    pc(1, 0, 0, 0);
    chk("frozen", 24'h00_0200, programCounter);
    clkEn = 1;
    vec(0, 7'h03, 24'h00_000A, 24'h00_0300);
    vec(1, 7'h00, 24'h00_0100, 24'h00_0220);
    @(posedge mclk) #1;
    {vecReq, vecAlt, vecIndex} = {1'b1, 1'b0, 7'h7E};
    @(posedge mclk) #1 vecReq = 0;
    chk("refused", 1, jumpRefused);
    chk("pc", 24'h00_0220, programCounter);
    @(posedge mclk) #1;
    pc(0, 0, 1, 24'h00_03FE);
    pc(1, 0, 0, 0);
    chk("fetch", 24'h00_0000, fetchWord);
    complete_run();
  end
endmodule
